// ### common/tlc_pkg.sv
package tlc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // Control register bit positions.
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_OVR_BIT = 1;
  localparam int CTRL_WFX_BIT = 2;
  localparam int CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // Status register bit positions.
  localparam int ST_LOW_BIT  = 0;
  localparam int ST_PAUS_BIT = 1;
  localparam int ST_OVF_BIT  = 2;
  localparam int ST_REC_BIT  = 3;
  localparam int ST_TA_BIT   = 4;
  localparam int ST_DBG_BIT  = 5;
  localparam int ST_VIEW_BIT = 6;

  // ----------------------------------------------------------------------
  // Trace elements emitted on the element port
  // ----------------------------------------------------------------------
  localparam int NUM_KIND = 7;
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam int K_DBG_EXC = 0;
  localparam int K_TRON    = 1;
  localparam int K_RST_EXC = 2;
  localparam int K_ATOM    = 3;
  localparam int K_COMMIT  = 4;
  localparam int K_OVF     = 5;
  localparam int K_EXC_OCC = 6;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LP_RUN   = 2'b00,
    LP_PAUSE = 2'b01,
    LP_DRAIN = 2'b10,
    LP_LOW   = 2'b11
  } tlc_lp_t;

  typedef enum logic [1:0] {
    OV_OK    = 2'b00,
    OV_HALT  = 2'b01,
    OV_RECOV = 2'b10
  } tlc_ovf_t;

endpackage : tlc_pkg

// ### verilog/tlc_ctl.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module tlc_ctl #(
  parameter int EXT_W = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              retention,
  input  wire logic              pe_wfx_sleep,
  input  wire logic              pe_debug,
  input  wire logic              pe_reset,
  input  wire logic              trace_allowed,
  input  wire logic              forced_reset_trace,
  input  wire logic              view_req,
  input  wire logic              res_paused,
  input  wire logic [EXT_W-1:0]  ext_evt,
  input  wire logic              wfx_atom_pending,
  input  wire logic              commit_pending,
  input  wire logic              exc_occ,
  input  wire logic              first_instr,
  input  wire logic              buf_overflow,
  input  wire logic              buf_recovered,
  input  wire logic              pkt_boundary,
  input  wire logic              sync_in_req,
  input  wire logic              sync_done,
  output logic                   pause_req,
  output logic [EXT_W-1:0]       ext_out,
  output logic                   instr_trace_en,
  output logic                   pkt_gate,
  output logic                   pkt_restrict,
  output logic                   sync_req,
  output logic                   elem_valid,
  output logic [2:0]             elem_kind,
  output logic                   lp_active
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    tlc_pkg::tlc_lp_t                lp_st;
    tlc_pkg::tlc_ovf_t               ov_st;
    logic [tlc_pkg::CTRL_W-1:0]      ctrl;
    logic                            ta;
    logic                            dbg_q;
    logic                            view_q;
    logic                            post_dbg;
    logic [tlc_pkg::NUM_KIND-1:0]    pend;
    logic                            sync_pend;
    logic                            sync_req;
    logic                            pause_req;
    logic [EXT_W-1:0]                ext_out;
    logic                            instr_en;
    logic                            pkt_gate;
    logic                            restrict_q;
    logic                            elem_valid;
    logic [2:0]                      elem_kind;
    logic                            pready;
    logic [31:0]                     prdata;
    logic                            pslverr;
    logic                            lp_q;
  } tlc_state_t;

  tlc_state_t st_ff;
  tlc_state_t nxt_st;

  logic lp_cond;
  logic view_live;
  logic acc_setup;
  logic acc_done;
  logic dbg_rise;
  logic dbg_fall;
  logic dbg_rst;
  logic emit_ok;
  logic hold_back;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // All decisions are made here so the whole block is one registered copy.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.elem_valid = 1'b0;
    nxt_st.elem_kind  = tlc_pkg::KIND_NONE;
    nxt_st.sync_req   = 1'b0;
    nxt_st.pready     = 1'b0;

    // One element per cycle, lowest index first; none while low-power.
    // This runs before the event logic, so an event that lands in the cycle
    // its element leaves queues it again instead of being lost.
    // An arriving overflow and the whole overflow window hold back every element but the overflow one,
    // which keeps every other emitted element outside the window that pkt_restrict shows.
    hold_back = st_ff.restrict_q | buf_overflow;
    emit_ok   = (st_ff.lp_st != tlc_pkg::LP_LOW);
    for (int k = 0; k < tlc_pkg::NUM_KIND; k++)
    begin
      if (emit_ok && st_ff.pend[k] && (!hold_back || k == tlc_pkg::K_OVF))
      begin
        emit_ok = 1'b0;
        nxt_st.elem_valid = 1'b1;
        nxt_st.elem_kind  = 3'(k + 1);
        nxt_st.pend[k]    = 1'b0;
      end
    end

    // Low-power is only legal while sleeping on a wait, in Debug or disabled.
    lp_cond = pe_wfx_sleep | pe_debug | ~st_ff.ctrl[tlc_pkg::CTRL_EN_BIT];

    // Bus: the answer comes one cycle into the access phase.
    acc_setup = psel & penable & ~st_ff.pready;
    acc_done  = psel & penable & st_ff.pready;
    if (acc_setup)
    begin
      nxt_st.pready  = 1'b1;
      nxt_st.prdata  = 32'h0;
      nxt_st.pslverr = 1'b0;
      if (retention)
      begin
        nxt_st.pslverr = 1'b1;
      end
      else if (paddr == tlc_pkg::OFS_CTRL)
      begin
        nxt_st.prdata[tlc_pkg::CTRL_W-1:0] = st_ff.ctrl;
      end
      else if (paddr == tlc_pkg::OFS_STATUS)
      begin
        nxt_st.prdata[tlc_pkg::ST_LOW_BIT]  = (st_ff.lp_st == tlc_pkg::LP_LOW);
        nxt_st.prdata[tlc_pkg::ST_PAUS_BIT] = st_ff.pause_req;
        nxt_st.prdata[tlc_pkg::ST_OVF_BIT]  = (st_ff.ov_st == tlc_pkg::OV_HALT);
        nxt_st.prdata[tlc_pkg::ST_REC_BIT]  = (st_ff.ov_st == tlc_pkg::OV_RECOV);
        nxt_st.prdata[tlc_pkg::ST_TA_BIT]   = st_ff.ta;
        nxt_st.prdata[tlc_pkg::ST_DBG_BIT]  = st_ff.dbg_q;
        nxt_st.prdata[tlc_pkg::ST_VIEW_BIT] = st_ff.view_q;
      end
      else
      begin
        nxt_st.pslverr = 1'b1;
      end
    end
    // Writes land at the completing edge; retention drops them and answers with pslverr.
    if (acc_done && pwrite && !retention && paddr == tlc_pkg::OFS_CTRL)
    begin
      nxt_st.ctrl = pwdata[tlc_pkg::CTRL_W-1:0];
    end

    // Debug tracking; a processing element reset counts as leaving Debug.
    dbg_rise = pe_debug & ~pe_reset & ~st_ff.dbg_q;
    dbg_rst  = st_ff.dbg_q & pe_reset;
    dbg_fall = st_ff.dbg_q & ~pe_debug & ~pe_reset;
    nxt_st.dbg_q = pe_debug & ~pe_reset;

    // View is forced off in Debug, on overflow and in low-power.
    view_live = view_req & ~pe_debug & st_ff.ctrl[tlc_pkg::CTRL_EN_BIT]
              & (st_ff.ov_st == tlc_pkg::OV_OK)
              & (st_ff.lp_st != tlc_pkg::LP_LOW);
    nxt_st.view_q = view_live;
    nxt_st.instr_en = view_live;

    if (dbg_rise)
    begin
      nxt_st.ta = st_ff.view_q;
      if (st_ff.view_q)
      begin
        nxt_st.pend[tlc_pkg::K_DBG_EXC] = 1'b1;
      end
    end
    if (dbg_fall && view_req)
    begin
      nxt_st.pend[tlc_pkg::K_TRON] = 1'b1;
    end
    if (dbg_fall)
    begin
      nxt_st.post_dbg = 1'b1;
    end
    else if (first_instr || dbg_rst)
    begin
      nxt_st.post_dbg = 1'b0;
    end
    if (dbg_rst && trace_allowed && (st_ff.ta || forced_reset_trace))
    begin
      nxt_st.pend[tlc_pkg::K_TRON]    = 1'b1;
      nxt_st.pend[tlc_pkg::K_RST_EXC] = 1'b1;
    end
    if (exc_occ && st_ff.post_dbg && st_ff.ta)
    begin
      nxt_st.pend[tlc_pkg::K_EXC_OCC] = 1'b1;
    end

    // Low-power sequence: pause resources, drain elements, then go quiet.
    case (st_ff.lp_st)
      tlc_pkg::LP_RUN:
      begin
        if (lp_cond && !st_ff.ctrl[tlc_pkg::CTRL_OVR_BIT])
        begin
          nxt_st.lp_st     = tlc_pkg::LP_PAUSE;
          nxt_st.pause_req = 1'b1;
        end
      end
      tlc_pkg::LP_PAUSE:
      begin
        if (!lp_cond || st_ff.ctrl[tlc_pkg::CTRL_OVR_BIT])
        begin
          nxt_st.lp_st     = tlc_pkg::LP_RUN;
          nxt_st.pause_req = 1'b0;
        end
        else if (res_paused)
        begin
          nxt_st.lp_st = tlc_pkg::LP_DRAIN;
          if (st_ff.ctrl[tlc_pkg::CTRL_WFX_BIT] && pe_wfx_sleep && wfx_atom_pending)
          begin
            nxt_st.pend[tlc_pkg::K_ATOM] = 1'b1;
          end
          if (commit_pending)
          begin
            nxt_st.pend[tlc_pkg::K_COMMIT] = 1'b1;
          end
        end
      end
      tlc_pkg::LP_DRAIN:
      begin
        // Entry waits for the elements and the last packet to finish.
        if (st_ff.pend == '0 && !st_ff.pkt_gate)
        begin
          nxt_st.lp_st = tlc_pkg::LP_LOW;
        end
      end
      tlc_pkg::LP_LOW:
      begin
        if (!lp_cond || st_ff.ctrl[tlc_pkg::CTRL_OVR_BIT])
        begin
          nxt_st.lp_st     = tlc_pkg::LP_RUN;
          nxt_st.pause_req = 1'b0;
        end
      end
      default:
      begin
        nxt_st.lp_st = tlc_pkg::LP_RUN;
      end
    endcase
    // Resources stay paused through drain and low-power.
    nxt_st.ext_out = (nxt_st.lp_st == tlc_pkg::LP_LOW) ? '0 : ext_evt;
    nxt_st.lp_q    = (nxt_st.lp_st == tlc_pkg::LP_LOW);

    // Overflow recovery.
    case (st_ff.ov_st)
      tlc_pkg::OV_OK:
      begin
        if (buf_overflow)
        begin
          nxt_st.ov_st = tlc_pkg::OV_HALT;
          nxt_st.pend[tlc_pkg::K_OVF] = 1'b1;
        end
      end
      tlc_pkg::OV_HALT:
      begin
        if (buf_recovered && !st_ff.pend[tlc_pkg::K_OVF])
        begin
          nxt_st.ov_st     = tlc_pkg::OV_RECOV;
          nxt_st.sync_pend = 1'b1;
        end
      end
      tlc_pkg::OV_RECOV:
      begin
        if (sync_done && !st_ff.sync_pend)
        begin
          nxt_st.ov_st = tlc_pkg::OV_OK;
        end
      end
      default:
      begin
        nxt_st.ov_st = tlc_pkg::OV_OK;
      end
    endcase
    nxt_st.restrict_q = (nxt_st.ov_st != tlc_pkg::OV_OK);

    // Packet gate only moves between packets so nothing leaves cut short.
    // It stays shut from the overflow until synchronization has completed.
    if (pkt_boundary)
    begin
      nxt_st.pkt_gate = (st_ff.lp_st == tlc_pkg::LP_RUN)
                      && (st_ff.ov_st == tlc_pkg::OV_OK);
    end

    // Synchronization requests are held while quiet; a new request wins.
    if (sync_in_req)
    begin
      nxt_st.sync_pend = 1'b1;
    end
    else if (st_ff.sync_pend && st_ff.lp_st != tlc_pkg::LP_LOW)
    begin
      nxt_st.sync_pend = 1'b0;
      nxt_st.sync_req  = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Every field resets to a constant; no port value is captured here.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '{lp_st: tlc_pkg::LP_RUN, ov_st: tlc_pkg::OV_OK, ctrl: tlc_pkg::CTRL_RST,
                 elem_kind: tlc_pkg::KIND_NONE, prdata: 32'h0, ext_out: '0, pend: '0,
                 default: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign prdata         = st_ff.prdata;
  assign pready         = st_ff.pready;
  assign pslverr        = st_ff.pslverr;
  assign pause_req      = st_ff.pause_req;
  assign ext_out        = st_ff.ext_out;
  assign instr_trace_en = st_ff.instr_en;
  assign pkt_gate       = st_ff.pkt_gate;
  assign pkt_restrict   = st_ff.restrict_q;
  assign sync_req       = st_ff.sync_req;
  assign elem_valid     = st_ff.elem_valid;
  assign elem_kind      = st_ff.elem_kind;
  assign lp_active      = st_ff.lp_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_lp_paused_first: assert property (
    $rose(st_ff.lp_st == tlc_pkg::LP_LOW) |-> $past(st_ff.pause_req, 2))
    else $error("Low-power entered without paused resources.");
  chk_lp_no_trace: assert property (
    (st_ff.lp_st == tlc_pkg::LP_LOW) [*2] |-> !elem_valid && !pkt_gate && !instr_trace_en)
    else $error("Trace produced while in low-power.");
  chk_lp_ext_low: assert property (
    lp_active |-> ext_out == '0)
    else $error("External outputs not low in low-power.");
  chk_override_stays: assert property (
    st_ff.ctrl[tlc_pkg::CTRL_OVR_BIT] && st_ff.lp_st == tlc_pkg::LP_RUN |=> st_ff.lp_st == tlc_pkg::LP_RUN)
    else $error("Low-power entered under override.");
  chk_debug_exc_emit: assert property (
    pe_debug && !pe_reset && !st_ff.dbg_q && st_ff.view_q && st_ff.pend == '0 && !st_ff.restrict_q
      && st_ff.lp_st != tlc_pkg::LP_LOW && st_ff.lp_st != tlc_pkg::LP_DRAIN
      |=> ##1 elem_valid && elem_kind == 3'(tlc_pkg::K_DBG_EXC + 1))
    else $error("Debug entry exception element missing.");
  chk_debug_no_instr: assert property (
    pe_debug |=> !instr_trace_en)
    else $error("Instruction trace enabled in Debug state.");
  chk_ovf_stops: assert property (
    st_ff.ov_st == tlc_pkg::OV_OK && buf_overflow |=> ##1 !instr_trace_en)
    else $error("Trace not stopped after overflow.");
  chk_ovf_restrict: assert property (
    elem_valid && pkt_restrict |-> elem_kind == 3'(tlc_pkg::K_OVF + 1))
    else $error("Non-overflow element during overflow window.");
  chk_retention_err: assert property (
    psel && penable && !pready && retention |=> pready && pslverr && prdata == 32'h0)
    else $error("Retention access did not answer as unpowered.");

endmodule : tlc_ctl

// ### tb/tlc_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: resources, packet framing and synchronisation
// ----------------------------------------------------------------
module tlc_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pause_req,
  input  wire logic sync_req,
  input  wire logic slow,
  output logic      res_paused,
  output logic      pkt_boundary,
  output logic      sync_done
);
  logic [3:0] ack_ff;
  logic [2:0] bnd_ff;
  logic [2:0] snc_ff;

  // A slow pause acknowledge and sparse packet ends shake out any design
  // that assumes pausing or framing is instant.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_ff <= 4'h0;
      bnd_ff <= 3'h0;
      snc_ff <= 3'h0;
    end
    else
    begin
      ack_ff <= {ack_ff[2:0], pause_req};
      bnd_ff <= (bnd_ff == (slow ? 3'h4 : 3'h1)) ? 3'h0 : bnd_ff + 3'h1;
      snc_ff <= sync_req ? 3'h4 : ((snc_ff != 3'h0) ? snc_ff - 3'h1 : 3'h0);
    end
  end

  // Responses decoded from the counters.
  assign res_paused   = slow ? ack_ff[3] : ack_ff[0];
  assign pkt_boundary = (bnd_ff == 3'h0);
  assign sync_done    = (snc_ff == 3'h1);
endmodule : tlc_far_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        retention, pe_wfx_sleep, pe_debug, pe_reset, trace_allowed, view_req, forced_reset_trace;
  logic        wfx_atom_pending, commit_pending, exc_occ, first_instr, buf_overflow;
  logic        buf_recovered, sync_in_req, slow, res_paused, pkt_boundary, sync_done;
  logic        pause_req, instr_trace_en, pkt_gate, pkt_restrict, sync_req, elem_valid, lp_active;
  logic [3:0]  ext_evt, ext_out;
  logic [2:0]  elem_kind;
  logic [2:0]  elems[$];
  int          fail_count, n_tests, sync_cnt;

  // Clock at 100 MHz.
  always #5 pclk = ~pclk;

  tlc_ctl #(.EXT_W(4)) dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .retention, .pe_wfx_sleep, .pe_debug, .pe_reset, .trace_allowed, .forced_reset_trace,
    .view_req, .res_paused, .ext_evt, .wfx_atom_pending, .commit_pending, .exc_occ, .first_instr,
    .buf_overflow, .buf_recovered, .pkt_boundary, .sync_in_req, .sync_done, .pause_req, .ext_out,
    .instr_trace_en, .pkt_gate, .pkt_restrict, .sync_req, .elem_valid, .elem_kind, .lp_active);

  tlc_far_model far_u (
    .pclk, .presetn, .pause_req, .sync_req, .slow, .res_paused, .pkt_boundary, .sync_done);

  // Elements and sync pulses are logged, so one-cycle pulses are never missed.
  always @(posedge pclk)
  begin
    if (elem_valid === 1'b1)
      elems.push_back(elem_kind);
    if (sync_req === 1'b1)
      sync_cnt++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task complete_run();
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A wait that runs out is a mismatch and ends the run.
  task hang();
    chk(32'h0, 32'h1);
    complete_run();
  endtask : hang

  function automatic logic [2:0] kc(input int k);
    return 3'(k + 1);
  endfunction : kc

  function automatic logic pick(input int w);
    case (w)
      0: return lp_active;
      1: return instr_trace_en;
      2: return pkt_restrict;
      3: return pkt_gate;
      4: return sync_cnt != 0;
      default: return pause_req;
    endcase
  endfunction : pick

  task wait_sig(input int w, input logic v);
    int i;
    for (i = 0; i < 300 && pick(w) !== v; i++)
      @(posedge pclk);
    if (pick(w) !== v)
      hang();
  endtask : wait_sig

  // Checks that a signal keeps one value for n cycles.
  task hold_chk(input int w, input logic v, input int n);
    int i;
    logic bad;
    bad = 1'b0;
    for (i = 0; i < n; i++)
    begin
      @(posedge pclk);
      bad = bad | (pick(w) !== v);
    end
    chk(32'(bad), 32'h0);
  endtask : hold_chk

  task get_elem(input logic [2:0] exp);
    int i;
    for (i = 0; i < 300 && elems.size() == 0; i++)
      @(posedge pclk);
    if (elems.size() == 0)
      hang();
    chk(32'(elems.pop_front()), 32'(exp));
  endtask : get_elem

  // APB transfer; the request holds until pready is sampled high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      hang();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(err), 32'(experr));
  endtask : rchk

  task pulse_exc();
    exc_occ <= 1'b1;
    @(posedge pclk);
    exc_occ <= 1'b0;
  endtask : pulse_exc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task regs_scn();
    rchk(tlc_pkg::OFS_CTRL, 32'(tlc_pkg::CTRL_RST), 1'b0);
    apb(1'b1, tlc_pkg::OFS_CTRL, 32'h3);
    rchk(tlc_pkg::OFS_CTRL, 32'h3, 1'b0);
    rchk(8'h08, 32'h0, 1'b1);
    retention <= 1'b1;
    apb(1'b1, tlc_pkg::OFS_CTRL, 32'h0);
    chk(32'(err), 32'h1);
    rchk(tlc_pkg::OFS_CTRL, 32'h0, 1'b1);
    retention <= 1'b0;
    rchk(tlc_pkg::OFS_CTRL, 32'h3, 1'b0);
  endtask : regs_scn

  task override_scn();
    ext_evt      <= 4'ha;
    pe_wfx_sleep <= 1'b1;
    hold_chk(5, 1'b0, 30);
    hold_chk(0, 1'b0, 4);
    chk(32'(ext_out), 32'ha);
    pe_wfx_sleep <= 1'b0;
  endtask : override_scn

  task lowpower_scn();
    apb(1'b1, tlc_pkg::OFS_CTRL, 32'h5);
    elems.delete();
    slow    <= 1'b1;
    ext_evt <= 4'h5;
    {wfx_atom_pending, commit_pending, pe_wfx_sleep} <= 3'h7;
    wait_sig(5, 1'b1);
    chk(32'(lp_active), 32'h0);
    wait_sig(0, 1'b1);
    chk(32'(elems.size()), 32'h2);
    get_elem(kc(tlc_pkg::K_ATOM));
    get_elem(kc(tlc_pkg::K_COMMIT));
    {wfx_atom_pending, commit_pending} <= 2'h0;
    sync_cnt = 0;
    sync_in_req <= 1'b1;
    @(posedge pclk);
    sync_in_req <= 1'b0;
    pulse_exc();
    hold_chk(0, 1'b1, 8);
    chk(32'(ext_out), 32'h0);
    chk(32'(elems.size()), 32'h0);
    chk(32'(pause_req), 32'h1);
    apb(1'b0, tlc_pkg::OFS_STATUS, 32'h0);
    chk(32'(rd[tlc_pkg::ST_LOW_BIT]), 32'h1);
    pe_wfx_sleep <= 1'b0;
    wait_sig(4, 1'b1);
    wait_sig(0, 1'b0);
    slow <= 1'b0;
    hold_chk(0, 1'b0, 8);
    chk(32'(elems.size()), 32'h0);
  endtask : lowpower_scn

  task debug_scn();
    apb(1'b1, tlc_pkg::OFS_CTRL, 32'h1);
    view_req <= 1'b1;
    wait_sig(1, 1'b1);
    elems.delete();
    pe_debug <= 1'b1;
    get_elem(kc(tlc_pkg::K_DBG_EXC));
    hold_chk(1, 1'b0, 12);
    pe_debug <= 1'b0;
    get_elem(kc(tlc_pkg::K_TRON));
    pulse_exc();
    get_elem(kc(tlc_pkg::K_EXC_OCC));
    first_instr <= 1'b1;
    @(posedge pclk);
    first_instr <= 1'b0;
    wait_sig(1, 1'b1);
  endtask : debug_scn

  task dbg_reset_scn();
    apb(1'b1, tlc_pkg::OFS_CTRL, 32'h3);
    elems.delete();
    pe_debug <= 1'b1;
    get_elem(kc(tlc_pkg::K_DBG_EXC));
    pe_reset <= 1'b1;
    @(posedge pclk);
    pe_reset <= 1'b0;
    get_elem(kc(tlc_pkg::K_TRON));
    get_elem(kc(tlc_pkg::K_RST_EXC));
    // Debug was re-entered with view inactive, so the flag is now clear.
    repeat (2) @(posedge pclk);
    pe_reset <= 1'b1;
    @(posedge pclk);
    pe_reset <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(elems.size()), 32'h0);
    forced_reset_trace <= 1'b1;
    pe_reset           <= 1'b1;
    @(posedge pclk);
    pe_reset           <= 1'b0;
    forced_reset_trace <= 1'b0;
    get_elem(kc(tlc_pkg::K_TRON));
    get_elem(kc(tlc_pkg::K_RST_EXC));
    pe_debug <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : dbg_reset_scn

  task overflow_scn();
    slow <= 1'b1;
    elems.delete();
    buf_overflow <= 1'b1;
    @(posedge pclk);
    buf_overflow <= 1'b0;
    get_elem(kc(tlc_pkg::K_OVF));
    wait_sig(2, 1'b1);
    wait_sig(3, 1'b0);
    pulse_exc();
    hold_chk(3, 1'b0, 6);
    chk(32'(elems.size()), 32'h0);
    sync_cnt = 0;
    buf_recovered <= 1'b1;
    wait_sig(4, 1'b1);
    chk(32'(pkt_gate), 32'h0);
    wait_sig(2, 1'b0);
    wait_sig(3, 1'b1);
    buf_recovered <= 1'b0;
    slow <= 1'b0;
  endtask : overflow_scn

  // Reset for 16 cycles, then the scenarios in turn.
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, retention, pe_wfx_sleep, pe_debug, pe_reset, view_req} = 8'h0;
    {wfx_atom_pending, commit_pending, exc_occ, first_instr, buf_overflow} = 5'h0;
    {buf_recovered, sync_in_req, slow} = 3'h0;
    trace_allowed = 1'b1;
    forced_reset_trace = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ext_evt = 4'h0;
    fail_count = 0;
    n_tests = 0;
    sync_cnt = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    regs_scn();
    override_scn();
    lowpower_scn();
    debug_scn();
    dbg_reset_scn();
    overflow_scn();
    complete_run();
  end

  // A stalled run still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge pclk);
    hang();
  end
endmodule : testbench
